// ==== design/timer_pkg.sv ====
// Purpose: shared constants, mode type and decode helpers of the two-channel timer
// Assumes: byte-wide register port, 16-bit counter
// Notes: channel value registers have no reset value
package timer_pkg;
  // register map, byte addresses
  localparam logic [7:0] ADDR_STATUS = 8'h20;
  localparam logic [7:0] ADDR_COUNT_HIGH = 8'h21;
  localparam logic [7:0] ADDR_COUNT_LOW = 8'h22;
  localparam logic [7:0] ADDR_MOD_HIGH = 8'h23;
  localparam logic [7:0] ADDR_MOD_LOW = 8'h24;
  localparam logic [7:0] ADDR_CHAN0_CTRL = 8'h25;
  localparam logic [7:0] ADDR_CHAN0_HIGH = 8'h26;
  localparam logic [7:0] ADDR_CHAN0_LOW = 8'h27;
  localparam logic [7:0] ADDR_CHAN1_CTRL = 8'h28;
  localparam logic [7:0] ADDR_CHAN1_HIGH = 8'h29;
  localparam logic [7:0] ADDR_CHAN1_LOW = 8'h2a;

  // channel control field positions
  localparam int CTRL_FLAG_BIT = 7;
  localparam int CTRL_BUF_BIT = 5;
  localparam int CTRL_UNBUF_BIT = 4;
  localparam int CTRL_ELS_HI_BIT = 3;
  localparam int CTRL_ELS_LO_BIT = 2;
  localparam int CTRL_TOV_BIT = 1;
  localparam int CTRL_MAX_BIT = 0;

  // status field positions
  localparam int STAT_FLAG_BIT = 7;
  localparam int STAT_STOP_BIT = 5;
  localparam int STAT_RESET_BIT = 4;
  localparam int STAT_PS_LSB = 0;

  // values after reset, and the unused prescaler select
  localparam logic STOP_RESET = 1'b1;
  localparam logic [15:0] MOD_RESET = 16'hffff;
  localparam logic [2:0] PS_RESET = 3'h0;
  localparam logic [2:0] PS_UNUSED = 3'h7;

  // least time the pin must be stable before capture is enabled, in bus clocks
  localparam int PIN_STABLE_CYCLES = 2;

  // edge/level field encodings
  localparam logic [1:0] ELS_OFF = 2'h0;
  localparam logic [1:0] ELS_TOGGLE_RISE = 2'h1;
  localparam logic [1:0] ELS_CLEAR_FALL = 2'h2;
  localparam logic [1:0] ELS_SET_ANY = 2'h3;

  typedef enum logic [1:0] {
    MODE_PRESET,
    MODE_CAPTURE,
    MODE_COMPARE,
    MODE_BUFFERED
  } chan_mode_e;

  // channel function from the mode and edge/level bits
  function automatic chan_mode_e chan_mode(input logic buf_sel, input logic unbuf_sel,
                                           input logic [1:0] els);
    if (els == ELS_OFF) begin
      chan_mode = MODE_PRESET;
    end else if (buf_sel) begin
      chan_mode = MODE_BUFFERED;
    end else if (unbuf_sel) begin
      chan_mode = MODE_COMPARE;
    end else begin
      chan_mode = MODE_CAPTURE;
    end
  endfunction : chan_mode

  // prescaler tap: true when the low ps bits of the divider are all ones, never when ps is PS_UNUSED
  function automatic logic presc_tick(input logic [5:0] presc, input logic [2:0] ps);
    logic [5:0] mask;
    mask = 6'((7'h1 << ps) - 7'h1);
    presc_tick = (ps != PS_UNUSED) && ((presc & mask) == mask);
  endfunction : presc_tick
endpackage : timer_pkg

// ==== design/chan_pin_sync.sv ====
// Purpose: two-stage synchroniser and edge detector for one channel pin
// Assumes: pin is asynchronous to clk_sys
// Notes: edges are one-cycle pulses, one to two cycles after the pin moves
`timescale 1ns/1ps
module chan_pin_sync (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic pin_in,
  output logic rise,
  output logic fall
);
  logic meta;
  logic stable;
  logic prev;

  // first stage feeds only the second
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      meta <= 1'b0;
      stable <= 1'b0;
      prev <= 1'b0;
    end else begin
      meta <= pin_in;
      stable <= meta;
      prev <= stable;
    end
  end

  // edges seen on the synchronised level
  assign rise = stable & ~prev;
  assign fall = ~stable & prev;
endmodule : chan_pin_sync

// ==== design/timer_channels.sv ====
// Purpose: two-channel capture/compare/PWM timer with counter, modulo and register port
// Assumes: single clock clk_sys, byte register port with read data one cycle later
// Notes: channel 0 may run buffered, using both value registers alternately
//
// Local design decision: the plain strobed port.
`timescale 1ns/1ps
module timer_channels
  import timer_pkg::*;
#(
  parameter int CNT_W = 16
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [7:0] addr,
  input wire logic [7:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [7:0] rd_data,
  input wire logic [1:0] channel_pin_in,
  output logic [1:0] channel_pin_out,
  output logic [1:0] channel_pin_oe,
  output logic [1:0] channel_connected,
  output logic counter_overflow_flag
);
  if (CNT_W != 16) begin : g_width_check
    $error("timer_channels serves a 16-bit counter only");
  end

  // control state
  logic [1:0][1:0] els;
  logic [1:0] unbuffered_mode_sel;
  logic chan0_buffered_sel;
  logic [1:0] toggle_on_overflow;
  logic [1:0] force_full_duty;
  logic [1:0] full_duty_now;
  logic [1:0] channel_event_flag;
  logic [1:0] chan_flag_armed;
  logic ovf_flag_armed;
  logic stop;
  logic [2:0] presc_sel;
  logic [5:0] presc;
  logic [15:0] count;
  logic [15:0] modulo;
  logic [7:0] mod_high_hold;
  logic [7:0] count_low_latch;
  logic [1:0][15:0] chan_value;
  logic [1:0] capture_block;
  logic [1:0] compare_block;
  logic active_sel;
  logic [1:0] pin_rise;
  logic [1:0] pin_fall;

  // decoded strobes and events
  chan_mode_e [1:0] mode;
  logic [1:0][1:0] eff_els;
  logic tick;
  logic overflow;
  logic [1:0] capture_ev;
  logic [1:0] match;
  logic [1:0] is_compare;
  logic [1:0][15:0] compare_value;
  logic [1:0] compare_blocked;
  logic [7:0] next_rd_data;
  logic wr_ctrl0;
  logic wr_ctrl1;
  logic wr_status;
  logic counter_clear;

  assign wr_ctrl0 = wr_en && (addr == ADDR_CHAN0_CTRL);
  assign wr_ctrl1 = wr_en && (addr == ADDR_CHAN1_CTRL) && !chan0_buffered_sel;
  assign wr_status = wr_en && (addr == ADDR_STATUS);
  assign counter_clear = wr_status && wr_data[STAT_RESET_BIT];

  // pin synchronisers, one per channel
  for (genvar c = 0; c < 2; c++) begin : g_sync
    chan_pin_sync u_sync (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .pin_in(channel_pin_in[c]),
      .rise(pin_rise[c]),
      .fall(pin_fall[c])
    );
  end

  // channel function and compare source decode
  always_comb begin
    eff_els[0] = els[0];
    eff_els[1] = chan0_buffered_sel ? ELS_OFF : els[1];
    mode[0] = chan_mode(chan0_buffered_sel, unbuffered_mode_sel[0], eff_els[0]);
    mode[1] = chan_mode(1'b0, unbuffered_mode_sel[1], eff_els[1]);
    compare_value[0] = chan0_buffered_sel ? chan_value[active_sel] : chan_value[0];
    compare_value[1] = chan_value[1];
    compare_blocked[0] = chan0_buffered_sel ? compare_block[active_sel] : compare_block[0];
    compare_blocked[1] = compare_block[1];
    for (int c = 0; c < 2; c++) begin
      is_compare[c] = chan0_buffered_sel ? (c == 0) : unbuffered_mode_sel[c];
      // a software-only compare still counts as compare mode when els is 00
      if (mode[c] == MODE_CAPTURE) begin
        is_compare[c] = 1'b0;
      end
      if (c == 1 && chan0_buffered_sel) begin
        is_compare[c] = 1'b0;
      end
      match[c] = tick && is_compare[c] && !compare_blocked[c]
                 && (count == compare_value[c]);
      capture_ev[c] = (mode[c] == MODE_CAPTURE) && !capture_block[c]
                      && ((eff_els[c] == ELS_TOGGLE_RISE && pin_rise[c])
                      || (eff_els[c] == ELS_CLEAR_FALL && pin_fall[c])
                      || (eff_els[c] == ELS_SET_ANY && (pin_rise[c] || pin_fall[c])));
    end
  end

  // prescaler and timer tick
  assign tick = !stop && presc_tick(presc, presc_sel);
  assign overflow = tick && (count == modulo);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      presc <= 6'h0;
    end else if (counter_clear || stop) begin
      presc <= 6'h0;
    end else begin
      presc <= presc + 6'h1;
    end
  end

  // counter restarts from zero after reaching modulo
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      count <= 16'h0;
    end else if (counter_clear) begin
      count <= 16'h0;
    end else if (overflow) begin
      count <= 16'h0;
    end else if (tick) begin
      count <= count + 16'h1;
    end
  end

  // status and modulo registers
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      stop <= STOP_RESET;
      presc_sel <= PS_RESET;
      modulo <= MOD_RESET;
      mod_high_hold <= MOD_RESET[15:8];
    end else begin
      if (wr_status) begin
        stop <= wr_data[STAT_STOP_BIT];
        presc_sel <= wr_data[STAT_PS_LSB +: 3];
      end
      if (wr_en && addr == ADDR_MOD_HIGH) begin
        mod_high_hold <= wr_data;
      end
      if (wr_en && addr == ADDR_MOD_LOW) begin
        modulo <= {mod_high_hold, wr_data};
      end
    end
  end

  // overflow flag: read while set arms the clear, a new overflow wins
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      counter_overflow_flag <= 1'b0;
      ovf_flag_armed <= 1'b0;
    end else begin
      if (overflow) begin
        counter_overflow_flag <= 1'b1;
        ovf_flag_armed <= 1'b0;
      end else if (wr_status && !wr_data[STAT_FLAG_BIT] && ovf_flag_armed) begin
        counter_overflow_flag <= 1'b0;
        ovf_flag_armed <= 1'b0;
      end else if (rd_en && addr == ADDR_STATUS && counter_overflow_flag) begin
        ovf_flag_armed <= 1'b1;
      end
    end
  end

  // channel control registers
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      els <= '0;
      toggle_on_overflow <= 2'h0;
      unbuffered_mode_sel <= 2'h0;
      force_full_duty <= 2'h0;
      chan0_buffered_sel <= 1'b0;
    end else begin
      if (wr_ctrl0) begin
        chan0_buffered_sel <= wr_data[CTRL_BUF_BIT];
        unbuffered_mode_sel[0] <= wr_data[CTRL_UNBUF_BIT];
        els[0] <= {wr_data[CTRL_ELS_HI_BIT], wr_data[CTRL_ELS_LO_BIT]};
        toggle_on_overflow[0] <= wr_data[CTRL_TOV_BIT];
        force_full_duty[0] <= wr_data[CTRL_MAX_BIT];
      end
      if (wr_ctrl1) begin
        unbuffered_mode_sel[1] <= wr_data[CTRL_UNBUF_BIT];
        els[1] <= {wr_data[CTRL_ELS_HI_BIT], wr_data[CTRL_ELS_LO_BIT]};
        toggle_on_overflow[1] <= wr_data[CTRL_TOV_BIT];
        force_full_duty[1] <= wr_data[CTRL_MAX_BIT];
      end
    end
  end

  // channel flags: events win over a clear in the same cycle
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      channel_event_flag <= 2'h0;
      chan_flag_armed <= 2'h0;
    end else begin
      for (int c = 0; c < 2; c++) begin
        if (capture_ev[c] || match[c]) begin
          channel_event_flag[c] <= 1'b1;
          chan_flag_armed[c] <= 1'b0;
        end else if ((c == 0 ? wr_ctrl0 : wr_ctrl1) && !wr_data[CTRL_FLAG_BIT]
                     && chan_flag_armed[c]) begin
          channel_event_flag[c] <= 1'b0;
          chan_flag_armed[c] <= 1'b0;
        end else if (rd_en && channel_event_flag[c]
                     && addr == (c == 0 ? ADDR_CHAN0_CTRL : ADDR_CHAN1_CTRL)) begin
          chan_flag_armed[c] <= 1'b1;
        end
      end
    end
  end

  // channel value registers, no reset; a software write wins over a capture
  always_ff @(posedge clk_sys) begin
    for (int c = 0; c < 2; c++) begin
      if (wr_en && addr == (c == 0 ? ADDR_CHAN0_HIGH : ADDR_CHAN1_HIGH)) begin
        chan_value[c][15:8] <= wr_data;
      end else if (wr_en && addr == (c == 0 ? ADDR_CHAN0_LOW : ADDR_CHAN1_LOW)) begin
        chan_value[c][7:0] <= wr_data;
      end else if (capture_ev[c]) begin
        chan_value[c] <= count;
      end
    end
  end

  // byte-access locks on the value registers
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      capture_block <= 2'h0;
      compare_block <= 2'h0;
    end else begin
      for (int c = 0; c < 2; c++) begin
        if (rd_en && addr == (c == 0 ? ADDR_CHAN0_HIGH : ADDR_CHAN1_HIGH)
            && mode[c] == MODE_CAPTURE) begin
          capture_block[c] <= 1'b1;
        end else if (rd_en && addr == (c == 0 ? ADDR_CHAN0_LOW : ADDR_CHAN1_LOW)) begin
          capture_block[c] <= 1'b0;
        end
        if (wr_en && addr == (c == 0 ? ADDR_CHAN0_HIGH : ADDR_CHAN1_HIGH)) begin
          compare_block[c] <= 1'b1;
        end else if (wr_en && addr == (c == 0 ? ADDR_CHAN0_LOW : ADDR_CHAN1_LOW)) begin
          compare_block[c] <= 1'b0;
        end
      end
    end
  end

  // buffered active register and period-aligned full-duty bit
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      active_sel <= 1'b0;
      full_duty_now <= 2'h0;
    end else begin
      if (!chan0_buffered_sel) begin
        active_sel <= 1'b0;
      end else if (overflow) begin
        active_sel <= ~active_sel;
      end
      if (overflow) begin
        full_duty_now <= force_full_duty;
      end
    end
  end

  // pin output level, ownership and drive
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      channel_pin_out <= 2'h0;
      channel_pin_oe <= 2'h0;
      channel_connected <= 2'h0;
    end else begin
      for (int c = 0; c < 2; c++) begin
        channel_connected[c] <= (mode[c] != MODE_PRESET);
        channel_pin_oe[c] <= (mode[c] == MODE_COMPARE) || (mode[c] == MODE_BUFFERED);
        if (mode[c] == MODE_PRESET) begin
          channel_pin_out[c] <= ~unbuffered_mode_sel[c];
        end else if (mode[c] == MODE_CAPTURE) begin
          channel_pin_out[c] <= channel_pin_out[c];
        end else if (toggle_on_overflow[c] && full_duty_now[c]
                     && eff_els[c] == ELS_CLEAR_FALL) begin
          channel_pin_out[c] <= 1'b1;
        end else if (toggle_on_overflow[c] && overflow) begin
          channel_pin_out[c] <= ~channel_pin_out[c];
        end else if (match[c]) begin
          case (eff_els[c])
            ELS_TOGGLE_RISE: channel_pin_out[c] <= ~channel_pin_out[c];
            ELS_CLEAR_FALL: channel_pin_out[c] <= 1'b0;
            ELS_SET_ANY: channel_pin_out[c] <= 1'b1;
            default: channel_pin_out[c] <= channel_pin_out[c];
          endcase
        end
      end
    end
  end

  // counter low byte latched by a high-byte read
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      count_low_latch <= 8'h0;
    end else if (rd_en && addr == ADDR_COUNT_HIGH) begin
      count_low_latch <= count[7:0];
    end
  end

  // read mux, unmapped addresses read zero
  always_comb begin
    next_rd_data = 8'h0;
    case (addr)
      ADDR_STATUS: next_rd_data = {counter_overflow_flag, 1'b0, stop, 2'h0, presc_sel};
      ADDR_COUNT_HIGH: next_rd_data = count[15:8];
      ADDR_COUNT_LOW: next_rd_data = count_low_latch;
      ADDR_MOD_HIGH: next_rd_data = modulo[15:8];
      ADDR_MOD_LOW: next_rd_data = modulo[7:0];
      ADDR_CHAN0_CTRL: next_rd_data = {channel_event_flag[0], 1'b0, chan0_buffered_sel,
                                       unbuffered_mode_sel[0], els[0],
                                       toggle_on_overflow[0], force_full_duty[0]};
      ADDR_CHAN1_CTRL: next_rd_data = chan0_buffered_sel ? 8'h0 :
                                      {channel_event_flag[1], 2'h0, unbuffered_mode_sel[1],
                                       els[1], toggle_on_overflow[1], force_full_duty[1]};
      ADDR_CHAN0_HIGH: next_rd_data = chan_value[0][15:8];
      ADDR_CHAN0_LOW: next_rd_data = chan_value[0][7:0];
      ADDR_CHAN1_HIGH: next_rd_data = chan_value[1][15:8];
      ADDR_CHAN1_LOW: next_rd_data = chan_value[1][7:0];
      default: next_rd_data = 8'h0;
    endcase
  end

  // read data registered for the cycle after the strobe
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rd_data <= 8'h0;
    end else if (rd_en) begin
      rd_data <= next_rd_data;
    end else begin
      rd_data <= 8'h0;
    end
  end
endmodule : timer_channels

// ==== testbench/timer_channels_asserts.sv ====
// Purpose: port-level checks of the two-channel timer
// Assumes: channel 0 control only changes through port writes
// Notes: channel 0 control bits are mirrored from the write strobe
`timescale 1ns/1ps
module timer_channels_asserts
  import timer_pkg::*;
#(
  parameter int CNT_W = 16
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [7:0] addr,
  input wire logic [7:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [7:0] rd_data,
  input wire logic [1:0] channel_pin_in,
  input wire logic [1:0] channel_pin_out,
  input wire logic [1:0] channel_pin_oe,
  input wire logic [1:0] channel_connected,
  input wire logic counter_overflow_flag
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  logic [7:0] ctrl0;
  logic wr0;
  // channel 0 control write strobe
  assign wr0 = wr_en && addr == ADDR_CHAN0_CTRL;
  // mirror of channel 0 control
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctrl0 <= 8'h00;
    end else if (wr0) begin
      ctrl0 <= wr_data;
    end
  end
  chk_preset_level: assert property (
    wr0 && wr_data[3:2] == ELS_OFF |-> ##2 channel_pin_out[0] == !$past(wr_data[4], 2))
    else $error("preset level wrong");
  chk_pin_connect: assert property (
    wr0 |-> ##2 channel_connected[0] == ($past(wr_data[3:2], 2) != ELS_OFF))
    else $error("pin ownership wrong");
  chk_oe_mode: assert property (
    wr0 |-> ##2 channel_pin_oe[0] ==
    ($past(wr_data[3:2], 2) != ELS_OFF && ($past(wr_data[5], 2) || $past(wr_data[4], 2))))
    else $error("pin drive does not follow mode");
  chk_ch1_off: assert property (ctrl0[5] |=> !channel_connected[1])
    else $error("channel 1 kept pin in buffered mode");
  chk_ch1_hidden: assert property (
    ctrl0[5] && rd_en && addr == ADDR_CHAN1_CTRL |=> rd_data == 8'h00)
    else $error("channel 1 control readable in buffered mode");
  chk_reset_clear: assert property (
    $rose(rst_n) |-> (channel_connected == 2'h0 && channel_pin_oe == 2'h0) [*2])
    else $error("channel owns pin after reset");
  chk_zero_duty: assert property (
    !wr_en && $stable(ctrl0) && ctrl0[5:0] == 6'h18 && !channel_pin_out[0]
    |=> !channel_pin_out[0])
    else $error("zero duty output rose");
  chk_set_hold: assert property (
    !wr_en && $stable(ctrl0) && ctrl0[5:0] == 6'h1c && channel_pin_out[0]
    |=> channel_pin_out[0])
    else $error("set on compare output fell");
  chk_ovf_sticky: assert property (
    counter_overflow_flag && !(wr_en && addr == ADDR_STATUS) |=> counter_overflow_flag)
    else $error("overflow flag dropped");
  // main scenarios reached
  cover property (wr0 && wr_data[5]);
  cover property ($rose(counter_overflow_flag));
  cover property (ctrl0[5:0] == 6'h1b && channel_pin_out[0]);
endmodule : timer_channels_asserts

bind timer_channels timer_channels_asserts #(.CNT_W(CNT_W)) timer_channels_asserts_i (
  .clk_sys(clk_sys), .rst_n(rst_n), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
  .rd_en(rd_en), .rd_data(rd_data), .channel_pin_in(channel_pin_in),
  .channel_pin_out(channel_pin_out), .channel_pin_oe(channel_pin_oe),
  .channel_connected(channel_connected), .counter_overflow_flag(counter_overflow_flag)
);

// ==== testbench/pin_source.sv ====
// Purpose: external signal source on both channel pins
// Assumes: the bench names the wanted level per pin
// Notes: a pin the timer drives follows the timer
`timescale 1ns/1ps
module pin_source #(
  parameter int LAG = 0
) (
  input wire logic clk_sys,
  input wire logic [1:0] want,
  input wire logic [1:0] pin_out,
  input wire logic [1:0] pin_oe,
  output logic [1:0] pin_in
);
  logic [1:0] level = 2'h0;
  // level moves only on clock edges, after a lag
  always begin
    @(posedge clk_sys);
    repeat (LAG) @(posedge clk_sys);
    level <= want;
  end
  // wire level from whoever drives it
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & level);
endmodule : pin_source

// ==== testbench/testbench.sv ====
// Purpose: directed tests of the two-channel timer over its byte port
// Assumes: timer clock undivided, modulo 15 once the counter runs
// Notes: pin levels come from the pin source model
`timescale 1ns/1ps
module testbench
  import timer_pkg::*;
;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wr_data = 8'h00;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [7:0] rd_data, d, c, v;
  logic [1:0] pin_in, pin_out, pin_oe, conn;
  logic [1:0] want = 2'h0;
  logic ovf, p;
  int n_errors = 0;
  int samples_checked = 0;

  // bench clock, 40 ns period
  always #20 clk_sys = ~clk_sys;

  timer_channels #(.CNT_W(16)) timer_channels_i (
    .clk_sys(clk_sys), .rst_n(rst_n), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
    .rd_en(rd_en), .rd_data(rd_data), .channel_pin_in(pin_in), .channel_pin_out(pin_out),
    .channel_pin_oe(pin_oe), .channel_connected(conn), .counter_overflow_flag(ovf)
  );
  pin_source #(.LAG(1)) pin_source_i (
    .clk_sys(clk_sys), .want(want), .pin_out(pin_out), .pin_oe(pin_oe), .pin_in(pin_in)
  );

  // one-cycle register write
  task automatic wr(input logic [7:0] a, input logic [7:0] x);
    @(posedge clk_sys);
    addr <= a;
    wr_data <= x;
    wr_en <= 1'b1;
    @(posedge clk_sys);
    wr_en <= 1'b0;
  endtask : wr
  // register read, data taken in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] x);
    @(posedge clk_sys);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk_sys);
    rd_en <= 1'b0;
    #1 x = rd_data;
  endtask : rd
  // byte comparison
  task automatic cmp_reg(input string n, input logic [7:0] e, input logic [7:0] s);
    samples_checked++;
    if (s !== e) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask : cmp_reg
  // pin comparison
  task automatic cmp_pin(input string n, input logic e, input logic s);
    samples_checked++;
    if (s !== e) begin
      n_errors++;
      $display("unexpected %s expected %b seen %b", n, e, s);
    end
  endtask : cmp_pin
  // read a register and compare it
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    rd(a, d);
    cmp_reg($sformatf("reg %h", a), e, d);
  endtask : rdc
  // whole cycles, then let the edge settle
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : cyc
  // cycles with channel 0 pin high
  task automatic high_count(input int n);
    c = 8'h00;
    repeat (n) begin
      @(posedge clk_sys);
      #1 c += {7'h0, pin_out[0]};
    end
  endtask : high_count
  // verdict
  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : finish_test

  // stop a hung run
  initial begin
    repeat (5000) @(posedge clk_sys);
    n_errors++;
    $display("watchdog expired");
    finish_test();
  end

  // test sequence
  initial begin
    repeat (16) @(posedge clk_sys);
    rst_n <= 1'b1;
    cyc(3);
    cmp_pin("pin0 preset", 1'b1, pin_out[0]);
    cmp_reg("owned", 8'h00, {6'h0, conn});
    rdc(ADDR_CHAN0_CTRL, 8'h00);
    rdc(ADDR_CHAN1_CTRL, 8'h00);
    rdc(8'h30, 8'h00);
    wr(ADDR_CHAN0_CTRL, 8'h10);
    cyc(2);
    cmp_pin("pin0 preset low", 1'b0, pin_out[0]);
    cmp_pin("pin0 free", 1'b0, conn[0]);
    wr(ADDR_CHAN1_HIGH, 8'ha5);
    wr(ADDR_CHAN1_LOW, 8'h5a);
    rdc(ADDR_CHAN1_HIGH, 8'ha5);
    rdc(ADDR_CHAN1_LOW, 8'h5a);
    wr(ADDR_STATUS, 8'h30);
    wr(ADDR_MOD_HIGH, 8'h00);
    wr(ADDR_MOD_LOW, 8'h0f);
    wr(ADDR_STATUS, 8'h00);
    cyc(20);
    cmp_pin("overflow flag", 1'b1, ovf);
    rdc(ADDR_STATUS, 8'h80);
    $display("test reset_preset done");
    // each capture edge choice, toggle bit set
    for (int e = 1; e < 4; e++) begin
      v = {4'h0, e[1:0], 2'h2};
      cyc(4);
      wr(ADDR_CHAN1_CTRL, v);
      want[1] <= 1'b1;
      cyc(8);
      rdc(ADDR_CHAN1_CTRL, v | {e[0], 7'h0});
      wr(ADDR_CHAN1_CTRL, v);
      want[1] <= 1'b0;
      cyc(8);
      rdc(ADDR_CHAN1_CTRL, v | {e[1], 7'h0});
      wr(ADDR_CHAN1_CTRL, v);
    end
    cmp_pin("pin1 driven", 1'b0, pin_oe[1]);
    cmp_pin("pin1 held", 1'b1, pin_out[1]);
    rd(ADDR_CHAN1_HIGH, d);
    want[1] <= 1'b1;
    cyc(8);
    rdc(ADDR_CHAN1_CTRL, 8'h0e);
    rd(ADDR_CHAN1_LOW, d);
    want[1] <= 1'b0;
    cyc(8);
    rdc(ADDR_CHAN1_CTRL, 8'h8e);
    $display("test capture done");
    wr(ADDR_CHAN0_HIGH, 8'h00);
    wr(ADDR_CHAN0_LOW, 8'h05);
    wr(ADDR_CHAN0_CTRL, 8'h1c);
    cyc(20);
    cmp_pin("set on match", 1'b1, pin_out[0]);
    rdc(ADDR_CHAN0_CTRL, 8'h9c);
    cmp_reg("pin0 owned", 8'h03, {6'h0, conn[0], pin_oe[0]});
    wr(ADDR_CHAN0_CTRL, 8'h18);
    cyc(20);
    cmp_pin("clear on match", 1'b0, pin_out[0]);
    wr(ADDR_CHAN0_HIGH, 8'h00);
    wr(ADDR_CHAN0_CTRL, 8'h1c);
    cyc(40);
    cmp_pin("match held off", 1'b0, pin_out[0]);
    wr(ADDR_CHAN0_LOW, 8'h05);
    cyc(20);
    cmp_pin("match resumed", 1'b1, pin_out[0]);
    wr(ADDR_CHAN0_CTRL, 8'h14);
    cyc(20);
    p = pin_out[0];
    cyc(16);
    cmp_pin("toggle on match", ~p, pin_out[0]);
    $display("test compare done");
    wr(ADDR_CHAN0_CTRL, 8'h1a);
    cyc(32);
    high_count(16);
    cmp_reg("pwm high", 8'h06, c);
    wr(ADDR_CHAN0_CTRL, 8'h1b);
    cyc(32);
    high_count(16);
    cmp_reg("full duty high", 8'h10, c);
    wr(ADDR_CHAN0_CTRL, 8'h1a);
    cyc(32);
    high_count(16);
    cmp_reg("duty restored", 8'h06, c);
    wr(ADDR_CHAN0_LOW, 8'h0f);
    cyc(32);
    p = pin_out[0];
    cyc(16);
    cmp_pin("overflow first", ~p, pin_out[0]);
    $display("test pwm done");
    wr(ADDR_CHAN0_LOW, 8'h05);
    wr(ADDR_CHAN1_HIGH, 8'h00);
    wr(ADDR_CHAN1_LOW, 8'h0a);
    wr(ADDR_CHAN0_CTRL, 8'h2a);
    cyc(3);
    cmp_pin("pin1 free", 1'b0, conn[1]);
    rdc(ADDR_CHAN1_CTRL, 8'h00);
    cyc(64);
    high_count(32);
    cmp_reg("buffered high", 8'h11, c);
    $display("test buffered done");
    finish_test();
  end
endmodule : testbench
